// ==== hdl/cmpc_pkg.sv ====
// Package: register map, field layout, reset values and codes of the mute and power control
package cmpc_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [6:0] ADDR_GLOBAL = 7'h02;
  localparam logic [6:0] ADDR_CHANNEL = 7'h09;
  localparam logic [6:0] ADDR_POWER = 7'h0a;
  localparam logic [6:0] ADDR_OSR = 7'h0b;
  localparam logic [6:0] ADDR_ADC = 7'h0c;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h1f;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_GLOBAL_MUTE = 0;
  localparam int POS_GLOBAL_DAC_CHANNEL_DEEMPHASIS = 1;
  localparam int POS_GLOBAL_DAC_GLOBAL_POWERDOWN = 2;
  localparam int POS_CH_MUTE = 3;
  localparam int POS_CH_DAC_CHANNEL_DEEMPHASIS = 6;
  localparam int POS_ADC_DISABLE = 0;
  localparam int POS_DAC_DISABLE = 1;
  localparam int POS_REF_DAC_GLOBAL_POWERDOWN = 4;
  localparam int POS_MASTER = 5;
  localparam int POS_RATE = 6;
  localparam int POS_OSR = 8;
  localparam int POS_ADC_MUTE_R = 0;
  localparam int POS_ADC_MUTE_L = 1;
  localparam int POS_ADC_MUTE_BOTH = 2;
  localparam int POS_HPF_DISABLE = 3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [8:0] RST_GLOBAL = 9'h000;
  localparam logic [8:0] RST_CHANNEL = 9'h000;
  localparam logic [8:0] RST_POWER = 9'h080;
  localparam logic [8:0] RST_OSR = 9'h000;
  localparam logic [8:0] RST_ADC = 9'h000;
  // ****************************************
  // Master clock to frame sync ratios
  // ****************************************
  typedef enum logic [2:0] {
    RATE_128 = 3'h0,
    RATE_192 = 3'h1,
    RATE_256 = 3'h2,
    RATE_384 = 3'h3,
    RATE_512 = 3'h4,
    RATE_768 = 3'h5
  } cmpc_rate_type;
  localparam int RAMP_W = 8;
endpackage

// ==== hdl/cmpc_top.sv ====
// Module: control registers and mute, de-emphasis, power and clock logic of the codec
`timescale 1ns/1ns
`default_nettype none
module cmpc_top #(
  parameter int CHANNELS = 3
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_strobe,
  input wire logic [6:0] i_wr_addr,
  input wire logic [8:0] i_wr_data,
  input wire logic [CHANNELS-1:0] i_dac_path_zero,
  input wire logic [CHANNELS-1:0] i_dac_atten_zero,
  output logic [CHANNELS-1:0] o_dac_softmute,
  output logic [CHANNELS-1:0] o_dac_hardmute,
  output logic [CHANNELS*cmpc_pkg::RAMP_W-1:0] o_dac_gain,
  output logic [CHANNELS-1:0] o_dac_deemphasis,
  output logic [CHANNELS-1:0] o_dac_channel_disable,
  output logic o_dac_history_clear,
  output logic o_dac_filter_init,
  output logic o_adc_right_silence,
  output logic o_adc_left_silence,
  output logic o_adc_disable,
  output logic o_adc_filter_init,
  output logic o_adc_os64,
  output logic o_adc_highpass_on,
  output logic o_reference_powerdown,
  output logic o_frame_sync_clock,
  output logic o_frame_sync_clock_oe,
  output logic o_bit_clock,
  output logic o_bit_clock_oe,
  output logic o_soft_reset_hold,
  output logic [8:0] o_rd_data,
  input wire logic [6:0] i_rd_addr
);
  // ****************************************
  // Register file
  // ****************************************
  logic [8:0] reg_global;
  logic [8:0] reg_channel;
  logic [8:0] reg_power;
  logic [8:0] reg_osr;
  logic [8:0] reg_adc;
  logic soft_hold;
  // Write decode: the reset address never lands in a register of its own
  wire wr_reset = i_wr_strobe && (i_wr_addr == cmpc_pkg::ADDR_SOFT_RESET);
  wire wr_ok = i_wr_strobe && !wr_reset && !soft_hold;

  // Register writes; soft reset holds defaults through the next write of any address
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || wr_reset) begin
      reg_global <= cmpc_pkg::RST_GLOBAL;
      reg_channel <= cmpc_pkg::RST_CHANNEL;
      reg_power <= cmpc_pkg::RST_POWER;
      reg_osr <= cmpc_pkg::RST_OSR;
      reg_adc <= cmpc_pkg::RST_ADC;
    end else if (wr_ok) begin
      if (i_wr_addr == cmpc_pkg::ADDR_GLOBAL) reg_global <= i_wr_data;
      if (i_wr_addr == cmpc_pkg::ADDR_CHANNEL) reg_channel <= i_wr_data;
      if (i_wr_addr == cmpc_pkg::ADDR_POWER) reg_power <= i_wr_data;
      if (i_wr_addr == cmpc_pkg::ADDR_OSR) reg_osr <= i_wr_data;
      if (i_wr_addr == cmpc_pkg::ADDR_ADC) reg_adc <= i_wr_data;
    end
  end

  // Hold flag: the releasing write itself is swallowed, registers stay at defaults
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      soft_hold <= 1'b0;
    end else if (wr_reset) begin
      soft_hold <= 1'b1;
    end else if (i_wr_strobe) begin
      soft_hold <= 1'b0;
    end
  end
  assign o_soft_reset_hold = soft_hold;

  // Read mux, unmapped addresses read zero
  always_comb begin
    unique case (i_rd_addr)
      cmpc_pkg::ADDR_GLOBAL: o_rd_data = reg_global;
      cmpc_pkg::ADDR_CHANNEL: o_rd_data = reg_channel;
      cmpc_pkg::ADDR_POWER: o_rd_data = reg_power;
      cmpc_pkg::ADDR_OSR: o_rd_data = reg_osr;
      cmpc_pkg::ADDR_ADC: o_rd_data = reg_adc;
      default: o_rd_data = 9'h000;
    endcase
  end

  // ****************************************
  // Field decode
  // ****************************************
  // Fields named once so the logic and the checks read the same bits
  wire global_mute = reg_global[cmpc_pkg::POS_GLOBAL_MUTE];
  wire global_dac_channel_deemphasis = reg_global[cmpc_pkg::POS_GLOBAL_DAC_CHANNEL_DEEMPHASIS];
  wire dac_global_powerdown = reg_global[cmpc_pkg::POS_GLOBAL_DAC_GLOBAL_POWERDOWN];
  wire [2:0] ch_mute = reg_channel[cmpc_pkg::POS_CH_MUTE +: 3];
  wire [2:0] ch_dac_channel_deemphasis = reg_channel[cmpc_pkg::POS_CH_DAC_CHANNEL_DEEMPHASIS +: 3];
  wire [2:0] ch_disable = reg_power[cmpc_pkg::POS_DAC_DISABLE +: 3];
  wire adc_dis = reg_power[cmpc_pkg::POS_ADC_DISABLE];
  wire master_sel = reg_power[cmpc_pkg::POS_MASTER];
  wire [2:0] rate_code = reg_power[cmpc_pkg::POS_RATE +: 3];
  wire osr_bit = reg_osr[cmpc_pkg::POS_OSR];
  wire adc_both = reg_adc[cmpc_pkg::POS_ADC_MUTE_BOTH];

  // ADC mutes and filter controls
  assign o_adc_right_silence = reg_adc[cmpc_pkg::POS_ADC_MUTE_R] | adc_both;
  assign o_adc_left_silence = reg_adc[cmpc_pkg::POS_ADC_MUTE_L] | adc_both;
  assign o_adc_highpass_on = !reg_adc[cmpc_pkg::POS_HPF_DISABLE];
  assign o_adc_disable = adc_dis;
  assign o_reference_powerdown = reg_power[cmpc_pkg::POS_REF_DAC_GLOBAL_POWERDOWN];
  assign o_dac_history_clear = dac_global_powerdown;
  // 64fs only where a 96kHz rate exists
  assign o_adc_os64 = osr_bit && (rate_code == 3'h2 || rate_code == 3'h3);

  // Falling edges of the DAC global powerdown and ADC disable bits restart the filters
  logic dac_global_powerdown_q;
  logic adc_dis_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dac_global_powerdown_q <= 1'b0;
      adc_dis_q <= 1'b0;
    end else begin
      dac_global_powerdown_q <= dac_global_powerdown;
      adc_dis_q <= adc_dis;
    end
  end
  assign o_dac_filter_init = dac_global_powerdown_q && !dac_global_powerdown;
  assign o_adc_filter_init = adc_dis_q && !adc_dis;

  // ****************************************
  // Per-channel mute, de-emphasis and disable
  // ****************************************
  // Soft ramp steps one per cycle; the filter scales its input by the gain
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic [cmpc_pkg::RAMP_W-1:0] gain;
    wire want_mute = ch_mute[c] | global_mute;
    wire hard = i_dac_path_zero[c] | i_dac_atten_zero[c] | dac_global_powerdown;
    always_ff @(posedge i_clk) begin
      if (i_sys_rst || hard) begin
        gain <= hard ? '0 : '1;
      end else if (want_mute && gain != '0) begin
        gain <= gain - 1'b1;
      end else if (!want_mute && gain != '1) begin
        gain <= gain + 1'b1;
      end
    end
    assign o_dac_gain[c*cmpc_pkg::RAMP_W +: cmpc_pkg::RAMP_W] = gain;
    assign o_dac_softmute[c] = want_mute;
    assign o_dac_hardmute[c] = hard;
    assign o_dac_deemphasis[c] = ch_dac_channel_deemphasis[c] | global_dac_channel_deemphasis;
    assign o_dac_channel_disable[c] = ch_disable[c] | dac_global_powerdown;
  end

  // ****************************************
  // Master mode clock generation
  // ****************************************
  // Half period of frame sync in master clocks; bit clock has 32 periods per frame
  logic [9:0] half_fs;
  always_comb begin
    unique case (rate_code)
      3'h0: half_fs = 10'd64;
      3'h1: half_fs = 10'd96;
      3'h2: half_fs = 10'd128;
      3'h3: half_fs = 10'd192;
      3'h4: half_fs = 10'd256;
      3'h5: half_fs = 10'd384;
      default: half_fs = 10'd128; // Reserved codes fall back to 256fs
    endcase
  end
  // Frame sync divider, held at zero in slave mode
  // Compare is >= so a switch to a shorter ratio never lets the counter wrap
  logic [9:0] div_cnt;
  logic fs_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !master_sel) begin
      div_cnt <= 10'd0;
      fs_q <= 1'b0;
    end else if (div_cnt >= half_fs - 10'd1) begin
      div_cnt <= 10'd0;
      fs_q <= !fs_q;
    end else begin
      div_cnt <= div_cnt + 10'd1;
    end
  end
  // Bit clock phase from the frame counter, so both clocks stay aligned
  logic [9:0] bit_div;
  assign bit_div = half_fs >> 5;
  logic bclk_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !master_sel) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= ((div_cnt / bit_div) % 10'd2) == 10'd1;
    end
  end
  assign o_frame_sync_clock = fs_q;
  assign o_bit_clock = bclk_q;
  assign o_frame_sync_clock_oe = master_sel;
  assign o_bit_clock_oe = master_sel;

  // ****************************************
  // Checks
  // ****************************************
  chk_hold_swallow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_reset ##1 i_wr_strobe |=> reg_global == cmpc_pkg::RST_GLOBAL)
    else $error("write during soft reset hold changed a register");
  chk_dac_global_powerdown_gain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dac_global_powerdown |=> o_dac_gain == '0)
    else $error("powerdown did not cut gain at once");
  chk_ramp_down: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    global_mute && !dac_global_powerdown && $past(global_mute) && o_dac_gain[7:0] != 8'h00
    |=> o_dac_gain[7:0] == $past(o_dac_gain[7:0]) - 8'h01 || dac_global_powerdown
    || i_dac_path_zero[0] || i_dac_atten_zero[0])
    else $error("soft mute ramp not one step");
  chk_disable_ovr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dac_global_powerdown |-> o_dac_channel_disable == '1)
    else $error("global powerdown did not disable all");
  chk_os_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_adc_os64 |-> rate_code inside {3'h2, 3'h3})
    else $error("64fs selected in wrong ratio");
  chk_filter_init: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(dac_global_powerdown) |-> o_dac_filter_init)
    else $error("filters not reinitialised");
  chk_adc_init: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(adc_dis) |-> o_adc_filter_init)
    else $error("ADC filters not reinitialised");
  chk_slave_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !master_sel |-> !o_frame_sync_clock_oe ##1 !o_frame_sync_clock)
    else $error("clock driven in slave mode");
  chk_adc_both: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    adc_both |-> o_adc_left_silence && o_adc_right_silence)
    else $error("both mute missed a side");

  // Ramps in both directions and the abrupt cut
  chk_ramp_up: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !global_mute && !ch_mute[0] && !g_ch[0].hard && o_dac_gain[7:0] != 8'hff
    |=> o_dac_gain[7:0] == $past(o_dac_gain[7:0]) + 8'h01)
    else $error("soft unmute ramp not one step");
  chk_chan_mute: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ch_mute[1] && !g_ch[1].hard && o_dac_gain[15:8] != 8'h00
    |=> o_dac_gain[15:8] < $past(o_dac_gain[15:8]))
    else $error("channel mute did not lower the gain");
  chk_path_cut: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_dac_path_zero[0] || i_dac_atten_zero[0] |=> o_dac_gain[7:0] == 8'h00)
    else $error("path or attenuation zero did not cut at once");

  // Powerdown keeps settings; register reset loads defaults
  chk_regs_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(dac_global_powerdown) |-> $stable(reg_channel) && $stable(reg_power) && $stable(reg_adc))
    else $error("powerdown changed a control register");
  chk_soft_defaults: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_reset |=> soft_hold && reg_power == cmpc_pkg::RST_POWER && reg_channel == 9'h000)
    else $error("register reset left a value or no hold");
  chk_adc_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    adc_dis |-> o_adc_disable && !o_adc_filter_init)
    else $error("ADC disable not applied");
  chk_ref_dac_global_powerdown: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    reg_power[cmpc_pkg::POS_REF_DAC_GLOBAL_POWERDOWN] |-> o_reference_powerdown)
    else $error("reference powerdown not applied");

  // Filter options
  chk_dac_channel_deemphasis_all: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    global_dac_channel_deemphasis |-> o_dac_deemphasis == '1)
    else $error("global de-emphasis missed a channel");
  chk_hpf_bypass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    reg_adc[cmpc_pkg::POS_HPF_DISABLE] |-> !o_adc_highpass_on)
    else $error("highpass not bypassed");

  // Frame sync toggles only at the divider end, bit clock quiet in slave mode
  chk_fs_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(master_sel) && $changed(o_frame_sync_clock)
    |-> $past(div_cnt) >= $past(half_fs) - 10'd1)
    else $error("frame sync toggled mid frame");
  chk_bclk_slave: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !master_sel |=> !o_bit_clock)
    else $error("bit clock runs in slave mode");

  // ****************************************
  // Coverage
  // ****************************************
  // Main scenarios the bench must reach
  cov_soft_reset: cover property (@(posedge i_clk) wr_reset ##1 i_wr_strobe);
  cov_master: cover property (@(posedge i_clk) master_sel && $rose(o_frame_sync_clock));
  cov_muted: cover property (@(posedge i_clk) global_mute && o_dac_gain[7:0] == 8'h00);
  cov_dac_global_powerdown_release: cover property (@(posedge i_clk) $fell(dac_global_powerdown));
  cov_os64: cover property (@(posedge i_clk) o_adc_os64 && master_sel);
endmodule
`default_nettype wire

// ==== verification/cmpc_host.sv ====
// Host model: single-cycle register writes on the control port
`timescale 1ns/1ns
`default_nettype none
module cmpc_host (
  input wire logic i_clk,
  output logic o_wr_strobe,
  output logic [6:0] o_wr_addr,
  output logic [8:0] o_wr_data
);
  initial begin
    o_wr_strobe = 1'b0;
    o_wr_addr = 7'h00;
    o_wr_data = 9'h000;
  end
  // Launch after an edge, hold through the taking edge
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge i_clk);
    #1;
    o_wr_strobe = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(posedge i_clk);
    #1;
    o_wr_strobe = 1'b0;
    // Idle bus shows junk so stale data never looks valid
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask
  // Two writes on consecutive edges, strobe held high between them
  task automatic wr2(input logic [6:0] a0, input logic [8:0] d0, input logic [6:0] a1,
      input logic [8:0] d1);
    @(posedge i_clk);
    #1;
    o_wr_strobe = 1'b1;
    o_wr_addr = a0;
    o_wr_data = d0;
    @(posedge i_clk);
    #1;
    o_wr_addr = a1;
    o_wr_data = d1;
    @(posedge i_clk);
    #1;
    o_wr_strobe = 1'b0;
    o_wr_addr = ~a1;
    o_wr_data = ~d1;
  endtask
  // Converters go down before the references
  task automatic full_powerdown();
    wr(cmpc_pkg::ADDR_POWER, 9'h08f);
    wr(cmpc_pkg::ADDR_POWER, 9'h09f);
  endtask
endmodule
`default_nettype wire

// ==== verification/codec_mute_power_control_tb.sv ====
// Testbench: control block against a reference model
`timescale 1ns/1ns
`default_nettype none
module codec_mute_power_control_tb;
  localparam logic [6:0] ADR [6] = '{7'h02, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h05};
  localparam int RATIO [6] = '{128, 192, 256, 384, 512, 768};
  // Bit clock grid of the block: 32 periods in each frame
  localparam int BCLK_PER_FRAME = 32;
  logic i_clk, i_sys_rst, stb, hist, dfi, ari, ale, adis, afi, os64, hpf, refpd, fs, fs_oe;
  logic bc, bc_oe, hold, m_hold, bc_q;
  logic [6:0] wa, rd_addr, a;
  logic [8:0] wd, rd_data, d, m_g, m_c, m_p, m_o, m_a;
  logic [2:0] pz, az, softm, hardm, dac_channel_deemphasis, chdis;
  logic [23:0] gain;
  logic [15:0] rnd;
  int mismatches, n_checks, cyc, n_dfi, n_afi, p, n_bc, b0;
  cmpc_host cmpc_host_inst (.i_clk(i_clk), .o_wr_strobe(stb), .o_wr_addr(wa), .o_wr_data(wd));
  cmpc_top cmpc_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_strobe(stb),
    .i_wr_addr(wa), .i_wr_data(wd), .i_dac_path_zero(pz), .i_dac_atten_zero(az),
    .o_dac_softmute(softm), .o_dac_hardmute(hardm), .o_dac_gain(gain),
    .o_dac_deemphasis(dac_channel_deemphasis), .o_dac_channel_disable(chdis), .o_dac_history_clear(hist),
    .o_dac_filter_init(dfi), .o_adc_right_silence(ari), .o_adc_left_silence(ale),
    .o_adc_disable(adis), .o_adc_filter_init(afi), .o_adc_os64(os64),
    .o_adc_highpass_on(hpf), .o_reference_powerdown(refpd), .o_frame_sync_clock(fs),
    .o_frame_sync_clock_oe(fs_oe), .o_bit_clock(bc), .o_bit_clock_oe(bc_oe),
    .o_soft_reset_hold(hold), .o_rd_data(rd_data), .i_rd_addr(rd_addr));
  // ****
  // Reference model and checks
  // ****
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic mdefault();
    m_g = cmpc_pkg::RST_GLOBAL;
    m_c = cmpc_pkg::RST_CHANNEL;
    m_p = cmpc_pkg::RST_POWER;
    m_o = cmpc_pkg::RST_OSR;
    m_a = cmpc_pkg::RST_ADC;
  endtask
  function automatic logic [8:0] mread(input logic [6:0] x);
    case (x)
      cmpc_pkg::ADDR_GLOBAL: return m_g;
      cmpc_pkg::ADDR_CHANNEL: return m_c;
      cmpc_pkg::ADDR_POWER: return m_p;
      cmpc_pkg::ADDR_OSR: return m_o;
      cmpc_pkg::ADDR_ADC: return m_a;
      default: return 9'h000;
    endcase
  endfunction
  // First write after a register reset only releases the hold
  task automatic mupd(input logic [6:0] x, input logic [8:0] v);
    if (m_hold)
      m_hold = 1'b0;
    else if (x == cmpc_pkg::ADDR_SOFT_RESET) begin
      mdefault();
      m_hold = 1'b1;
    end else if (x == cmpc_pkg::ADDR_GLOBAL)
      m_g = v;
    else if (x == cmpc_pkg::ADDR_CHANNEL)
      m_c = v;
    else if (x == cmpc_pkg::ADDR_POWER)
      m_p = v;
    else if (x == cmpc_pkg::ADDR_OSR)
      m_o = v;
    else if (x == cmpc_pkg::ADDR_ADC)
      m_a = v;
  endtask
  task automatic w(input logic [6:0] x, input logic [8:0] v);
    cmpc_host_inst.wr(x, v);
    mupd(x, v);
  endtask
  task automatic w2(input logic [6:0] x0, input logic [8:0] v0, input logic [6:0] x1,
      input logic [8:0] v1);
    cmpc_host_inst.wr2(x0, v0, x1, v1);
    mupd(x0, v0);
    mupd(x1, v1);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_all();
    chk(softm, m_c[5:3] | {3{m_g[0]}});
    chk(hardm, pz | az | {3{m_g[2]}});
    chk(dac_channel_deemphasis, m_c[8:6] | {3{m_g[1]}});
    chk(chdis, m_p[3:1] | {3{m_g[2]}});
    chk({hist, adis, refpd}, {m_g[2], m_p[0], m_p[4]});
    chk({ari, ale}, {m_a[0] | m_a[2], m_a[1] | m_a[2]});
    chk(os64, {m_o[8] & (m_p[8:6] == 3'h2 || m_p[8:6] == 3'h3)});
    chk(hpf, {~m_a[3]});
    chk({fs_oe, bc_oe, hold}, {m_p[5], m_p[5], m_hold});
    foreach (ADR[k]) begin
      rd_addr = ADR[k];
      #1;
      chk(rd_data, mread(ADR[k]));
    end
  endtask
  // Frame sync period counted in master clock edges
  task automatic frame_period(output int n);
    n = 0;
    while (fs !== 1'b1 && n < 900) begin
      @(posedge i_clk);
      n++;
    end
    n = 0;
    while (fs !== 1'b0 && n < 900) begin
      @(posedge i_clk);
      n++;
    end
    while (fs !== 1'b1 && n < 900) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  // Next state of the stimulus shift register
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic waitc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Pulse counters and hang limit
  always @(posedge i_clk) begin
    cyc++;
    n_dfi += int'(dfi === 1'b1);
    n_afi += int'(afi === 1'b1);
    n_bc += int'(bc === 1'b1 && bc_q === 1'b0);
    bc_q = bc;
    if (cyc == 30000) begin
      mismatches++;
      $display("ERROR at %0t: run did not finish", $time);
      complete_run();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {mismatches, n_checks, cyc, n_dfi, n_afi, n_bc} = 0;
    i_sys_rst = 1'b1;
    {pz, az, rd_addr, m_hold} = 0;
    rnd = 16'd23;
    mdefault();
    waitc(16);
    i_sys_rst = 1'b0;
    check_all();
    // Soft ramp, global then one channel
    w(cmpc_pkg::ADDR_GLOBAL, 9'h001);
    waitc(8);
    chk({gain[7:0] > 8'hef && gain[7:0] < 8'hff}, 1);
    waitc(260);
    chk(gain, 24'h000000);
    w(cmpc_pkg::ADDR_GLOBAL, 9'h000);
    w(cmpc_pkg::ADDR_CHANNEL, 9'h010);
    waitc(270);
    chk(gain, 24'hff00ff);
    // Powerdown and filter reinitialisation
    w(cmpc_pkg::ADDR_GLOBAL, 9'h004);
    w(cmpc_pkg::ADDR_POWER, 9'h08f);
    check_all();
    w(cmpc_pkg::ADDR_GLOBAL, 9'h000);
    w(cmpc_pkg::ADDR_POWER, 9'h080);
    waitc(4);
    chk(n_dfi, 1);
    chk(n_afi, 1);
    cmpc_host_inst.full_powerdown();
    m_p = 9'h09f;
    check_all();
    w(cmpc_pkg::ADDR_OSR, 9'h100);
    foreach (RATIO[r]) begin
      w(cmpc_pkg::ADDR_POWER, {r[2:0], 6'h20});
      check_all();
      frame_period(p);
      b0 = n_bc;
      frame_period(p);
      chk(p, RATIO[r]);
      chk(n_bc - b0, BCLK_PER_FRAME);
    end
    repeat (40) begin
      rnd = lfsr(rnd);
      a = ADR[rnd % 6];
      rnd = lfsr(rnd);
      d = rnd[8:0];
      if (a == cmpc_pkg::ADDR_POWER && d[8:6] > 3'h5)
        d[8] = 1'b0;
      pz = rnd[11:9];
      az = rnd[14:12];
      w(a, d);
      check_all();
    end
    // Register reset and the swallowed write
    w(cmpc_pkg::ADDR_SOFT_RESET, 9'h000);
    check_all();
    w(cmpc_pkg::ADDR_GLOBAL, 9'h005);
    check_all();
    w(cmpc_pkg::ADDR_GLOBAL, 9'h005);
    check_all();
    // Register reset and a write on the very next edge
    w2(cmpc_pkg::ADDR_SOFT_RESET, 9'h000, cmpc_pkg::ADDR_GLOBAL, 9'h003);
    check_all();
    i_sys_rst = 1'b1;
    waitc(2);
    i_sys_rst = 1'b0;
    mdefault();
    check_all();
    complete_run();
  end
endmodule
`default_nettype wire
